// ===== sle_pkg.sv
// Shared types and constants for the front-panel indicator encoder.
// Assumes a single 200 MHz system clock; no bus, all controls are plain ports.
package sle_pkg;

	// Indicator drive: two colour bits, yellow is red plus green
	typedef struct packed {
		logic red;
		logic green;
	} sle_led_type;

	localparam sle_led_type LED_OFF = 2'h0;
	localparam sle_led_type LED_GREEN = 2'h1;
	localparam sle_led_type LED_RED = 2'h2;
	localparam sle_led_type LED_YELLOW = 2'h3;

	// Source-priority setting encodings
	typedef enum logic [1:0] {
		SLE_MODE_AB = 2'h0,
		SLE_MODE_BA = 2'h1,
		SLE_MODE_A = 2'h2,
		SLE_MODE_B = 2'h3
	} sle_mode_type;

	// Selected input encodings
	typedef enum logic [1:0] {
		SLE_SEL_NONE = 2'h0,
		SLE_SEL_A = 2'h1,
		SLE_SEL_B = 2'h2
	} sle_sel_type;

	// Per-input status carried together
	typedef struct packed {
		logic present;
		logic dis_enable;
		logic dis_assert;
	} sle_input_type;

	// Power supply status carried together
	typedef struct packed {
		logic good;
		logic redundant_fitted;
		logic one_failed;
	} sle_power_type;

	// Blink timing: half period of the flash in nanoseconds
	localparam int BLINK_HALF_NS = 250000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
	localparam logic BLINK_RESET = 1'h0;

endpackage : sle_pkg

// ===== sle_encoder.sv
// Front-panel indicator encoder: power, two inputs, N outputs, alarm.
// Assumes all status inputs are synchronous to clk and drive LED drivers directly.
//
// Function
// - Power indicator green while supply health reports good.
// - Power indicator red when one of a redundant supply pair failed.
// - Power indicator off when no redundant supply is fitted.
// - Input indicator steady green while that input is selected.
// - Steady red when input required but signal absent.
// - Flashing red when required and its enabled disable pin is asserted.
// - Steady yellow when present but another source or none selected.
// - Flashing yellow when present, not required, disable enabled and asserted.
// - Off when signal absent and not required.
// - Required flags derive from setting; single-source A leaves B not required.
// - Output indicator green while output present and healthy.
// - Output indicator red when absent, shorted or driver failed.
// - Alarm indicator green while no alarm bit active.
// - Alarm indicator red whenever any alarm bit active.
// - Setting is AB, BA, A only or B only; single-source has no secondary.
// - Input fault is lost presence or enabled disable pin high.
`timescale 1ns/1ps
module sle_encoder
	import sle_pkg::*;
#(
	parameter int NUM_OUTPUTS = 10,
	parameter int NUM_ALARMS = 16,
	parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration
	input wire sle_mode_type mode,
	input wire sle_sel_type selected,
	// Status inputs
	input wire sle_power_type power,
	input wire sle_input_type in_a,
	input wire sle_input_type in_b,
	input wire logic [NUM_OUTPUTS-1:0] out_present,
	input wire logic [NUM_OUTPUTS-1:0] out_shorted,
	input wire logic [NUM_OUTPUTS-1:0] out_driver_fail,
	input wire logic [NUM_ALARMS-1:0] alarm_bits,
	// Indicator drives
	output sle_led_type led_power,
	output sle_led_type led_in_a,
	output sle_led_type led_in_b,
	output sle_led_type [NUM_OUTPUTS-1:0] led_out,
	output sle_led_type led_alarm,
	// Input fault flags, useful to the switching logic
	output logic fault_a,
	output logic fault_b
);

	localparam int CW = $clog2(BLINK_CYCLES + 1);

	// Elaboration check: the divider needs two counts per half period,
	// and every lamp group at least one member
	if (NUM_OUTPUTS < 1 || NUM_ALARMS < 1 || BLINK_CYCLES < 2) begin : bad_params
		$error("sle_encoder: parameter out of range");
	end

	typedef struct packed {
		logic [CW-1:0] count;
		logic blink;
		sle_led_type power;
		sle_led_type in_a;
		sle_led_type in_b;
		sle_led_type [NUM_OUTPUTS-1:0] outs;
		sle_led_type alarm;
		logic fault_a;
		logic fault_b;
	} sle_state_type;

	sle_state_type state;
	sle_state_type next_state;

	// Required-presence flags per setting
	function automatic logic required(input sle_mode_type m, input logic is_b);
		case (m)
			SLE_MODE_A: required = !is_b;
			SLE_MODE_B: required = is_b;
			default: required = 1'b1;
		endcase
	endfunction : required

	// Fault: lost presence or enabled disable pin asserted
	function automatic logic in_fault(input sle_input_type s);
		in_fault = !s.present || (s.dis_enable && s.dis_assert);
	endfunction : in_fault

	// Colour of one input indicator; flashes use the shared blink phase
	function automatic sle_led_type in_colour(input sle_input_type s, input logic req,
		input logic sel, input logic blink);
		logic dis;
		dis = s.dis_enable && s.dis_assert;
		if (req && dis) begin
			in_colour = blink ? LED_RED : LED_OFF;
		end else if (s.present && !req && dis) begin
			in_colour = blink ? LED_YELLOW : LED_OFF;
		end else if (sel) begin
			in_colour = LED_GREEN;
		end else if (req && !s.present) begin
			in_colour = LED_RED;
		end else if (s.present) begin
			in_colour = LED_YELLOW;
		end else begin
			in_colour = LED_OFF;
		end
	endfunction : in_colour

	// Next-state logic: blink divider and all indicator colours
	always_comb begin
		next_state = state;
		// One divider for every flashing indicator keeps them in phase
		if (state.count >= CW'(BLINK_CYCLES - 1)) begin
			next_state.count = '0;
			next_state.blink = !state.blink;
		end else begin
			next_state.count = state.count + CW'(1);
		end
		// Power: missing redundant supply overrides, then failure, then good
		if (!power.redundant_fitted) begin
			next_state.power = LED_OFF;
		end else if (power.one_failed) begin
			next_state.power = LED_RED;
		end else if (power.good) begin
			next_state.power = LED_GREEN;
		end else begin
			next_state.power = LED_RED;
		end
		// Input lamps share one decoder so A and B cannot drift apart
		next_state.in_a = in_colour(in_a, required(mode, 1'b0),
			selected == SLE_SEL_A, state.blink);
		next_state.in_b = in_colour(in_b, required(mode, 1'b1),
			selected == SLE_SEL_B, state.blink);
		// Fault flags feed the switching logic; registered like the lamps
		next_state.fault_a = in_fault(in_a);
		next_state.fault_b = in_fault(in_b);
		// Output lamps: any one fault turns the lamp red
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			if (out_present[i] && !out_shorted[i] && !out_driver_fail[i]) begin
				next_state.outs[i] = LED_GREEN;
			end else begin
				next_state.outs[i] = LED_RED;
			end
		end
		// Alarm lamp only summarises; the details stay in the alarm bits
		next_state.alarm = (|alarm_bits) ? LED_RED : LED_GREEN;
	end

	// State register; indicators reset dark
	// Synchronous reset only, so nothing reaches the lamps without the clock
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flip-flops
	assign led_power = state.power;
	assign led_in_a = state.in_a;
	assign led_in_b = state.in_b;
	assign led_out = state.outs;
	assign led_alarm = state.alarm;
	assign fault_a = state.fault_a;
	assign fault_b = state.fault_b;

	// Check terms taken from the pins, apart from the next-state logic
	logic chk_dis_a;
	logic chk_dis_b;
	logic chk_req_a;
	logic chk_req_b;
	assign chk_dis_a = in_a.dis_enable && in_a.dis_assert;
	assign chk_dis_b = in_b.dis_enable && in_b.dis_assert;
	assign chk_req_a = mode != SLE_MODE_B;
	assign chk_req_b = mode != SLE_MODE_A;

	// Assertions
	power_green_a: assert property (@(posedge clk) disable iff (reset)
		power.redundant_fitted && !power.one_failed && power.good |=> led_power == LED_GREEN)
		else $error("power not green when good");
	power_red_a: assert property (@(posedge clk) disable iff (reset)
		power.redundant_fitted && power.one_failed |=> led_power == LED_RED)
		else $error("power not red on supply failure");
	power_off_a: assert property (@(posedge clk) disable iff (reset)
		!power.redundant_fitted |=> led_power == LED_OFF)
		else $error("power not off without redundant supply");
	sel_green_a: assert property (@(posedge clk) disable iff (reset)
		selected == SLE_SEL_A && !(in_a.dis_enable && in_a.dis_assert)
		|=> led_in_a == LED_GREEN)
		else $error("selected input not green");
	req_red_a: assert property (@(posedge clk) disable iff (reset)
		mode != SLE_MODE_B && !in_a.present && selected != SLE_SEL_A
		&& !(in_a.dis_enable && in_a.dis_assert) |=> led_in_a == LED_RED)
		else $error("required absent input not red");
	b_not_req_a: assert property (@(posedge clk) disable iff (reset)
		mode == SLE_MODE_A && !in_b.present && selected != SLE_SEL_B
		|=> led_in_b == LED_OFF)
		else $error("input b lit while not required");
	out_led_a: assert property (@(posedge clk) disable iff (reset)
		out_shorted[0] |=> led_out[0] == LED_RED)
		else $error("shorted output not red");
	alarm_led_a: assert property (@(posedge clk) disable iff (reset)
		(|alarm_bits) |=> led_alarm == LED_RED)
		else $error("alarm indicator not red");
	alarm_clear_a: assert property (@(posedge clk) disable iff (reset)
		alarm_bits == '0 |=> led_alarm == LED_GREEN)
		else $error("alarm indicator not green");
	b_sel_green_a: assert property (@(posedge clk) disable iff (reset)
		selected == SLE_SEL_B && !chk_dis_b |=> led_in_b == LED_GREEN)
		else $error("selected input b not green");
	b_req_red_a: assert property (@(posedge clk) disable iff (reset)
		chk_req_b && !in_b.present && selected != SLE_SEL_B && !chk_dis_b
		|=> led_in_b == LED_RED)
		else $error("required absent input b not red");
	present_yellow_a: assert property (@(posedge clk) disable iff (reset)
		in_a.present && selected != SLE_SEL_A && !chk_dis_a |=> led_in_a == LED_YELLOW)
		else $error("present unselected input a not yellow");
	b_present_yellow_a: assert property (@(posedge clk) disable iff (reset)
		in_b.present && selected != SLE_SEL_B && !chk_dis_b |=> led_in_b == LED_YELLOW)
		else $error("present unselected input b not yellow");
	a_not_req_a: assert property (@(posedge clk) disable iff (reset)
		mode == SLE_MODE_B && !in_a.present && selected != SLE_SEL_A
		|=> led_in_a == LED_OFF)
		else $error("input a lit while not required");

	// Flashing states override selection and presence
	flash_red_a: assert property (@(posedge clk) disable iff (reset)
		chk_req_a && chk_dis_a |=> led_in_a == ($past(state.blink) ? LED_RED : LED_OFF))
		else $error("disabled required input a not flashing red");
	b_flash_red_a: assert property (@(posedge clk) disable iff (reset)
		chk_req_b && chk_dis_b |=> led_in_b == ($past(state.blink) ? LED_RED : LED_OFF))
		else $error("disabled required input b not flashing red");
	flash_yellow_a: assert property (@(posedge clk) disable iff (reset)
		in_b.present && !chk_req_b && chk_dis_b
		|=> led_in_b == ($past(state.blink) ? LED_YELLOW : LED_OFF))
		else $error("misconfigured input b not flashing yellow");
	a_flash_yellow_a: assert property (@(posedge clk) disable iff (reset)
		in_a.present && !chk_req_a && chk_dis_a
		|=> led_in_a == ($past(state.blink) ? LED_YELLOW : LED_OFF))
		else $error("misconfigured input a not flashing yellow");

	// Fault flags follow the pins with one cycle of latency
	fault_set_a: assert property (@(posedge clk) disable iff (reset)
		!in_a.present || chk_dis_a |=> fault_a)
		else $error("input a fault not flagged");
	fault_clear_a: assert property (@(posedge clk) disable iff (reset)
		in_a.present && !chk_dis_a |=> !fault_a)
		else $error("input a fault flagged without cause");
	b_fault_set_a: assert property (@(posedge clk) disable iff (reset)
		!in_b.present || chk_dis_b |=> fault_b)
		else $error("input b fault not flagged");
	b_fault_clear_a: assert property (@(posedge clk) disable iff (reset)
		in_b.present && !chk_dis_b |=> !fault_b)
		else $error("input b fault flagged without cause");

	// Supply fitted but not reporting good is treated as a failure
	power_bad_a: assert property (@(posedge clk) disable iff (reset)
		power.redundant_fitted && !power.one_failed && !power.good |=> led_power == LED_RED)
		else $error("power not red when not good");

	// Shared divider: flashing lamps stay in phase and start dark after reset
	flash_phase_a: assert property (@(posedge clk) disable iff (reset)
		chk_req_a && chk_dis_a && chk_req_b && chk_dis_b |=> led_in_a == led_in_b)
		else $error("flashing lamps out of phase");
	div_range_a: assert property (@(posedge clk) disable iff (reset)
		state.count < CW'(BLINK_CYCLES))
		else $error("blink divider out of range");
	blink_hold_a: assert property (@(posedge clk) disable iff (reset)
		state.count != CW'(BLINK_CYCLES - 1) |=> $stable(state.blink))
		else $error("blink phase moved early");
	blink_flip_a: assert property (@(posedge clk) disable iff (reset)
		state.count == CW'(BLINK_CYCLES - 1) |=> state.blink != $past(state.blink))
		else $error("blink phase did not toggle");
	blink_reset_a: assert property (@(posedge clk)
		reset |=> state.blink == BLINK_RESET && led_in_a == LED_OFF && led_power == LED_OFF)
		else $error("indicators not dark after reset");

	// Every output lamp follows its own health bits, lamp by lamp
	for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : out_checks
		out_green_a: assert property (@(posedge clk) disable iff (reset)
			out_present[g] && !out_shorted[g] && !out_driver_fail[g]
			|=> led_out[g] == LED_GREEN)
			else $error("healthy output not green");
		out_red_a: assert property (@(posedge clk) disable iff (reset)
			!out_present[g] || out_shorted[g] || out_driver_fail[g]
			|=> led_out[g] == LED_RED)
			else $error("failed output not red");
	end

	// Any single alarm bit is enough to turn the alarm lamp red
	for (genvar g = 0; g < NUM_ALARMS; g++) begin : alarm_checks
		alarm_bit_a: assert property (@(posedge clk) disable iff (reset)
			alarm_bits[g] |=> led_alarm == LED_RED)
			else $error("alarm bit did not turn lamp red");
	end

endmodule : sle_encoder

// ===== sle_panel_model.sv
// Front-panel lamp seen by an operator: counts clocks with the lamp lit.
// Assumes the lamp drive is registered on clk; colour codes from sle_pkg.
`timescale 1ns/1ps
module sle_panel_model
	import sle_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Lamp drive
	input wire sle_led_type led,
	// Observation
	output int lit_count
);
	// Operator only notices lit cycles, flashing or steady alike; unknown drive stays dark
	always @(posedge clk) begin
		if (reset)
			lit_count <= 0;
		else if (led.red === 1'b1 || led.green === 1'b1)
			lit_count <= lit_count + 1;
	end
endmodule : sle_panel_model

// ===== test_status_led_encoder.sv
// Random self-checking bench for the indicator encoder against a behavioural model.
// Assumes one cycle latency on all indicators; flash phase predicted from the divider length.
`timescale 1ns/1ps
module test_status_led_encoder;
	import sle_pkg::*;
	logic clk;
	logic reset;
	sle_mode_type mode;
	sle_sel_type selected;
	sle_power_type power;
	sle_input_type in_a;
	sle_input_type in_b;
	logic [9:0] out_present, out_shorted, out_driver_fail;
	logic [15:0] alarm_bits;
	sle_led_type led_power, led_in_a, led_in_b, led_alarm;
	sle_led_type [9:0] led_out, exp_out;
	logic fault_a, fault_b, req_a, req_b, phase;
	sle_led_type exp_a, exp_b;
	int errors, checks, seed, lit_count, exp_lit, ticks;
	// Short half period so the flash toggles many times in a run
	localparam int BLINK = 4;

	sle_encoder #(.NUM_OUTPUTS(10), .NUM_ALARMS(16), .BLINK_CYCLES(BLINK)) dut_u (.clk(clk),
		.reset(reset), .mode(mode), .selected(selected), .power(power), .in_a(in_a),
		.in_b(in_b), .out_present(out_present), .out_shorted(out_shorted),
		.out_driver_fail(out_driver_fail), .alarm_bits(alarm_bits), .led_power(led_power),
		.led_in_a(led_in_a), .led_in_b(led_in_b), .led_out(led_out), .led_alarm(led_alarm),
		.fault_a(fault_a), .fault_b(fault_b));
	sle_panel_model lamp_u (.clk(clk), .reset(reset), .led(led_in_a), .lit_count(lit_count));

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task summarize;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// Top bit marks a flashing state; priority order kept by the return order
	function automatic logic [2:0] in_exp(sle_input_type i, logic req, logic sel);
		if (req && i.dis_enable && i.dis_assert) return {1'b1, LED_RED};
		if (i.present && !req && i.dis_enable && i.dis_assert) return {1'b1, LED_YELLOW};
		if (sel) return {1'b0, LED_GREEN};
		if (req && !i.present) return {1'b0, LED_RED};
		if (i.present) return {1'b0, LED_YELLOW};
		return {1'b0, LED_OFF};
	endfunction : in_exp

	// A flashing lamp is dark in the off half of the shared blink
	function automatic sle_led_type lamp(logic [2:0] e, logic ph);
		return (e[2] && !ph) ? LED_OFF : sle_led_type'(e[1:0]);
	endfunction : lamp

	function automatic logic fault_of(sle_input_type i);
		return !i.present || (i.dis_enable && i.dis_assert);
	endfunction : fault_of

	task drive;
		mode = sle_mode_type'(2'($random(seed)));
		selected = sle_sel_type'(($random(seed) & 32'h7fffffff) % 3);
		{power, in_a, in_b} = 9'($random(seed));
		{out_present, out_shorted, out_driver_fail} = 30'({$random(seed), $random(seed)});
		alarm_bits = ($random(seed) & 1) ? 16'h0 : 16'h1 << ($random(seed) & 15);
	endtask : drive

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard: about twice the 2011 cycles the run needs
	initial begin
		#20000;
		errors++;
		summarize();
	end

	initial begin
		seed = 35;
		reset = 1;
		drive();
		repeat (10) @(posedge clk);
		#1;
		// All lamps dark and both flags low while reset holds
		check("led_power", led_power, LED_OFF);
		check("reset lamps", {led_in_a, led_in_b, led_alarm, led_out, fault_a, fault_b}, 0);
		reset = 0;
		drive();
		for (ticks = 1; ticks <= 2000; ticks++) begin
			@(posedge clk);
			#1;
			req_a = mode != SLE_MODE_B;
			req_b = mode != SLE_MODE_A;
			// Lamps shown at edge k used the blink phase left by edge k-1
			phase = ((ticks - 1) / BLINK) % 2 == 1;
			exp_a = lamp(in_exp(in_a, req_a, selected == SLE_SEL_A), phase);
			exp_b = lamp(in_exp(in_b, req_b, selected == SLE_SEL_B), phase);
			exp_lit += (exp_a != LED_OFF);
			check("led_power", led_power, !power.redundant_fitted ? LED_OFF :
				(power.one_failed || !power.good) ? LED_RED : LED_GREEN);
			check("led_in_a", led_in_a, exp_a);
			check("led_in_b", led_in_b, exp_b);
			check("fault_a", fault_a, fault_of(in_a));
			check("fault_b", fault_b, fault_of(in_b));
			for (int k = 0; k < 10; k++)
				exp_out[k] = (out_present[k] && !out_shorted[k] && !out_driver_fail[k]) ?
					LED_GREEN : LED_RED;
			check("led_out", led_out, exp_out);
			check("led_alarm", led_alarm, |alarm_bits ? LED_RED : LED_GREEN);
			drive();
		end
		// One more edge so the lamp model has seen the last result
		@(posedge clk);
		#1;
		check("lamp lit", lit_count, exp_lit);
		summarize();
	end
endmodule : test_status_led_encoder
